// ===== hdl/nfc_defs.vh
// Constants for the NOR flash command host controller
`ifndef NFC_DEFS_VH
`define NFC_DEFS_VH
`define NFC_ADDR_W      22
`define NFC_UNLOCK_A1   11'h555
`define NFC_UNLOCK_A2   11'h2aa
`define NFC_UNLOCK_D1   16'h00aa
`define NFC_UNLOCK_D2   16'h0055
`define NFC_CMD_RESET   16'h00f0
`define NFC_CMD_AUTOSEL 16'h0090
`define NFC_CMD_PROG    16'h00a0
`define NFC_CMD_ERASE   16'h0080
`define NFC_CMD_CHIP    16'h0010
`define NFC_CMD_SECTOR  16'h0030
`define NFC_CMD_SUSPEND 16'h00b0
`define NFC_CMD_RESUME  16'h0030
`define NFC_CMD_FAST    16'h0020
`define NFC_CMD_PROT    16'h0060
`define NFC_CMD_PROT2   16'h0040
`define NFC_CMD_QUERY   16'h0098
`define NFC_CMD_SECURE  16'h0088
`define NFC_CMD_SECEXIT 16'h0000
`define NFC_QUERY_A     11'h055
`define NFC_PROT_LOW    7'h02
`define NFC_ID_DEV      8'h01
`define NFC_ID_EXT1     8'h0e
`define NFC_ID_EXT2     8'h0f
`define NFC_SECURE_TOP  22'h00007f
`define NFC_CLK_MHZ     50
`define NFC_T_READY_US  20
`define NFC_T_SPD_US    20
`define NFC_T_BUSY_NS   90
`define NFC_T_PROG_US   100
`define NFC_T_ERASE_MS  2000
`define NFC_CYC_READY   (`NFC_T_READY_US * `NFC_CLK_MHZ)
`define NFC_CYC_SPD     (`NFC_T_SPD_US * `NFC_CLK_MHZ)
`define NFC_CYC_BUSY    (`NFC_T_BUSY_NS * `NFC_CLK_MHZ / 1000)
`define NFC_CYC_PROG    (`NFC_T_PROG_US * `NFC_CLK_MHZ)
`define NFC_CYC_ERASE   (`NFC_T_ERASE_MS * 1000 * `NFC_CLK_MHZ)
`define NFC_CYC_RST     4
`define NFC_CYC_PHASE   4
`define NFC_OP_RESET    4'h0
`define NFC_OP_PROG     4'h1
`define NFC_OP_CHIP     4'h2
`define NFC_OP_SECTOR   4'h3
`define NFC_OP_SUSPEND  4'h4
`define NFC_OP_RESUME   4'h5
`define NFC_OP_AUTOSEL  4'h6
`define NFC_OP_FAST     4'h7
`define NFC_OP_FASTEXIT 4'h8
`define NFC_OP_PROT     4'h9
`define NFC_OP_QUERY    4'ha
`define NFC_OP_SECURE   4'hb
`define NFC_OP_SECEXIT  4'hc
`define NFC_OP_READ     4'hd
`define NFC_OP_HWRESET  4'he
`endif

// ===== hdl/nfc_seq_rom.v
// Command sequence table: address and data of each bus write
`timescale 1ns/1ps
`default_nettype none
`include "nfc_defs.vh"
module nfc_seq_rom (
  input  wire        mclk,
  input  wire [3:0]  op,
  input  wire [2:0]  idx,
  input  wire        fast,
  output reg  [1:0]  akind,
  output reg  [10:0] alow,
  output reg  [15:0] dat,
  output reg         last
);
  // akind: 0 fixed low address, 1 bank address, 2 user address, 3 protect address
  reg [1:0]  k;
  reg [10:0] a;
  reg [15:0] d;
  reg        l;
  reg [2:0]  j;
  always @* begin
    k = 2'd0;
    a = `NFC_UNLOCK_A1;
    d = `NFC_CMD_RESET;
    l = 1'b0;
    j = idx;
    // Erase repeats the unlock pair after the 80h write
    if ((op == `NFC_OP_CHIP || op == `NFC_OP_SECTOR) && idx >= 3'd3)
      j = idx - 3'd3;
    case (j)
      3'd0: begin
        a = `NFC_UNLOCK_A1;
        d = `NFC_UNLOCK_D1;
      end
      3'd1: begin
        a = `NFC_UNLOCK_A2;
        d = `NFC_UNLOCK_D2;
      end
      default: begin
        a = `NFC_UNLOCK_A1;
        d = `NFC_CMD_RESET;
      end
    endcase
    case (op)
      `NFC_OP_RESET: begin
        d = `NFC_CMD_RESET;
        l = 1'b1;
      end
      `NFC_OP_PROG: begin
        if (fast) begin
          if (idx == 3'd0) d = `NFC_CMD_PROG;
          else begin
            k = 2'd2;
            d = 16'h0000;
            l = 1'b1;
          end
        end else if (idx == 3'd2) d = `NFC_CMD_PROG;
        else if (idx == 3'd3) begin
          k = 2'd2;
          l = 1'b1;
        end
      end
      `NFC_OP_CHIP, `NFC_OP_SECTOR: begin
        if (idx == 3'd2) d = `NFC_CMD_ERASE;
        else if (idx == 3'd5) begin
          l = 1'b1;
          if (op == `NFC_OP_CHIP) d = `NFC_CMD_CHIP;
          else begin
            k = 2'd2;
            d = `NFC_CMD_SECTOR;
          end
        end
      end
      `NFC_OP_SUSPEND, `NFC_OP_RESUME: begin
        k = 2'd1;
        l = 1'b1;
        d = (op == `NFC_OP_SUSPEND) ? `NFC_CMD_SUSPEND : `NFC_CMD_RESUME;
      end
      `NFC_OP_AUTOSEL, `NFC_OP_FAST, `NFC_OP_SECURE: begin
        if (idx == 3'd2) begin
          l = 1'b1;
          k = (op == `NFC_OP_AUTOSEL) ? 2'd1 : 2'd0;
          d = (op == `NFC_OP_AUTOSEL) ? `NFC_CMD_AUTOSEL :
              (op == `NFC_OP_FAST) ? `NFC_CMD_FAST : `NFC_CMD_SECURE;
        end
      end
      `NFC_OP_FASTEXIT: begin
        k = 2'd1;
        d = (idx == 3'd0) ? `NFC_CMD_AUTOSEL : `NFC_CMD_RESET;
        l = (idx == 3'd1);
      end
      `NFC_OP_PROT: begin
        k = (idx == 3'd0) ? 2'd0 : 2'd3;
        d = (idx == 3'd2) ? `NFC_CMD_PROT2 : `NFC_CMD_PROT;
        l = (idx == 3'd2);
      end
      `NFC_OP_QUERY: begin
        k = 2'd1;
        a = `NFC_QUERY_A;
        d = `NFC_CMD_QUERY;
        l = 1'b1;
      end
      `NFC_OP_SECEXIT: begin
        if (idx == 3'd2) begin
          k = 2'd1;
          d = `NFC_CMD_AUTOSEL;
        end else if (idx == 3'd3) begin
          d = `NFC_CMD_SECEXIT;
          l = 1'b1;
        end
      end
      default: begin
        l = 1'b1;
      end
    endcase
  end
  always @(posedge mclk) begin
    akind <= k;
    alow  <= a;
    dat   <= d;
    last  <= l;
  end
endmodule
`default_nettype wire

// ===== hdl/nfc_host.v
// Host controller issuing NOR flash command sequences over the async bus
// Summary of operation
// - F0h alone or after unlock resets
// - Unlock is AAh@555h then 55h@2AAh
// - Only listed sequences are ever issued
// - Program: unlock, A0h@555h, data at target; in fast mode no unlock
// - Erase: six writes, 10h chip, 30h sector
// - Protect address low bits are 0,0,0,1,0
// - Secure exit sent to bank zero
`timescale 1ns/1ps
`default_nettype none
`include "nfc_defs.vh"
module nfc_host #(
  parameter AW        = `NFC_ADDR_W,
  parameter CYC_READY = `NFC_CYC_READY,
  parameter CYC_SPD   = `NFC_CYC_SPD,
  parameter CYC_PROG  = `NFC_CYC_PROG,
  parameter CYC_ERASE = `NFC_CYC_ERASE
) (
  input  wire          mclk,
  input  wire          rst_b,
  input  wire          cmd_valid,
  output wire          cmd_ready,
  input  wire [3:0]    cmd_op,
  input  wire [AW-1:0] cmd_addr,
  input  wire [15:0]   cmd_data,
  output reg           done_r,
  output reg           err_r,
  output reg  [15:0]   rdata_r,
  input  wire          elevated_id_voltage,
  output reg  [AW-1:0] flash_addr_r,
  input  wire [15:0]   flash_dq_in,
  output reg  [15:0]   flash_dq_out_r,
  output reg           flash_dq_oe_b_r,
  output reg           flash_chip_select_b_r,
  output reg           flash_we_b_r,
  output reg           flash_oe_b_r,
  output reg           flash_reset_b_r,
  input  wire          ready_busy_out
);
  localparam S_IDLE = 3'd0;
  localparam S_LOAD = 3'd1;
  localparam S_WLOW = 3'd2;
  localparam S_WHI  = 3'd3;
  localparam S_POLL = 3'd4;
  localparam S_WAIT = 3'd5;
  localparam S_READ = 3'd6;
  localparam S_RST  = 3'd7;
  reg [1:0]  rs_r;
  wire       rst_n = rs_r[1];
  reg [2:0]  st_r;
  reg [3:0]  op_r;
  reg [AW-1:0] a_r;
  reg [15:0] d_r;
  reg [2:0]  idx_r;
  reg [2:0]  ph_r;
  reg [31:0] cnt_r;
  reg        fast_r;
  reg        secure_r;
  reg        bad_r;
  wire [1:0]  akind;
  wire [10:0] alow;
  wire [15:0] sdat;
  wire        slast;
  nfc_seq_rom u_rom (
    .mclk  (mclk),
    .op    (op_r),
    .idx   (idx_r),
    .fast  (fast_r),
    .akind (akind),
    .alow  (alow),
    .dat   (sdat),
    .last  (slast)
  );
  function legal;
    input [3:0] o;
    input       f;
    input       s;
    input       v;
    begin
      case (o)
        `NFC_OP_FASTEXIT: legal = f;
        `NFC_OP_PROT:     legal = v;
        `NFC_OP_SECEXIT:  legal = s;
        `NFC_OP_HWRESET, `NFC_OP_READ, `NFC_OP_RESET: legal = 1'b1;
        default:          legal = (o <= `NFC_OP_SECURE) && !(f && o != `NFC_OP_PROG);
      endcase
    end
  endfunction
  assign cmd_ready = (st_r == S_IDLE);
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rs_r <= 2'b00;
    else rs_r <= {rs_r[0], 1'b1};
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      op_r <= `NFC_OP_RESET;
      a_r <= {AW{1'b0}};
      d_r <= 16'h0000;
      idx_r <= 3'd0;
      ph_r <= 3'd0;
      cnt_r <= 32'd0;
      fast_r <= 1'b0;
      secure_r <= 1'b0;
      bad_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 16'h0000;
      flash_addr_r <= {AW{1'b0}};
      flash_dq_out_r <= 16'h0000;
      flash_dq_oe_b_r <= 1'b1;
      flash_chip_select_b_r <= 1'b1;
      flash_we_b_r <= 1'b1;
      flash_oe_b_r <= 1'b1;
      flash_reset_b_r <= 1'b1;
    end else begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          idx_r <= 3'd0;
          ph_r <= 3'd0;
          cnt_r <= 32'd0;
          if (cmd_valid) begin
            a_r <= cmd_addr;
            d_r <= cmd_data;
            // Refused request: send F0h, report error once it is written
            if (!legal(cmd_op, fast_r, secure_r, elevated_id_voltage)) begin
              op_r <= `NFC_OP_RESET;
              bad_r <= 1'b1;
              st_r <= S_LOAD;
            end else begin
              bad_r <= 1'b0;
              op_r <= cmd_op;
              if (cmd_op == `NFC_OP_HWRESET) st_r <= S_RST;
              else if (cmd_op == `NFC_OP_READ) st_r <= S_READ;
              else st_r <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          st_r <= S_WLOW;
        end
        S_WLOW: begin
          ph_r <= ph_r + 3'd1;
          if (ph_r == 3'd0) begin
            case (akind)
              2'd1: flash_addr_r <= {a_r[AW-1:AW-3], {(AW-14){1'b0}}, alow};
              2'd2: flash_addr_r <= a_r;
              2'd3: flash_addr_r <= {a_r[AW-1:12], 5'h00, `NFC_PROT_LOW};
              default: flash_addr_r <= {{(AW-11){1'b0}}, alow};
            endcase
            if (op_r == `NFC_OP_SECEXIT) flash_addr_r[AW-1:AW-3] <= 3'b000;
            flash_dq_out_r <= (akind == 2'd2 && op_r == `NFC_OP_PROG) ? d_r : sdat;
            flash_dq_oe_b_r <= 1'b0;
            flash_oe_b_r <= 1'b1;
          end else if (ph_r == 3'd1) begin
            flash_chip_select_b_r <= 1'b0;
            flash_we_b_r <= 1'b0;
          end else if (ph_r == `NFC_CYC_PHASE) begin
            flash_we_b_r <= 1'b1;
            ph_r <= 3'd0;
            st_r <= S_WHI;
          end
        end
        S_WHI: begin
          flash_chip_select_b_r <= 1'b1;
          ph_r <= ph_r + 3'd1;
          if (ph_r == 3'd1) begin
            flash_dq_oe_b_r <= 1'b1;
            ph_r <= 3'd0;
            if (!slast) begin
              idx_r <= idx_r + 3'd1;
              st_r <= S_LOAD;
            end else begin
              cnt_r <= 32'd0;
              case (op_r)
                `NFC_OP_PROG, `NFC_OP_CHIP, `NFC_OP_SECTOR: st_r <= S_POLL;
                `NFC_OP_SUSPEND: st_r <= S_WAIT;
                `NFC_OP_FAST: begin
                  fast_r <= 1'b1;
                  st_r <= S_IDLE;
                  done_r <= 1'b1;
                end
                `NFC_OP_FASTEXIT: begin
                  fast_r <= 1'b0;
                  st_r <= S_IDLE;
                  done_r <= 1'b1;
                end
                `NFC_OP_SECURE: begin
                  secure_r <= 1'b1;
                  st_r <= S_IDLE;
                  done_r <= 1'b1;
                end
                `NFC_OP_SECEXIT: begin
                  secure_r <= 1'b0;
                  st_r <= S_IDLE;
                  done_r <= 1'b1;
                end
                `NFC_OP_PROT: begin
                  a_r <= {a_r[AW-1:12], 5'h00, `NFC_PROT_LOW};
                  st_r <= S_READ;
                end
                default: begin
                  st_r <= S_IDLE;
                  done_r <= !bad_r;
                  err_r <= bad_r;
                end
              endcase
            end
          end
        end
        S_POLL: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r > `NFC_CYC_BUSY && ready_busy_out) begin
            flash_oe_b_r <= 1'b1;
            flash_chip_select_b_r <= 1'b1;
            st_r <= S_IDLE;
            done_r <= 1'b1;
          end else if (cnt_r >= ((op_r == `NFC_OP_PROG) ? CYC_PROG : CYC_ERASE)) begin
            flash_oe_b_r <= 1'b1;
            flash_chip_select_b_r <= 1'b1;
            err_r <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_WAIT: begin
          cnt_r <= cnt_r + 32'd1;
          flash_reset_b_r <= !(op_r == `NFC_OP_HWRESET && cnt_r < `NFC_CYC_RST);
          if (cnt_r >= ((op_r == `NFC_OP_HWRESET) ? CYC_READY + `NFC_CYC_RST : CYC_SPD)) begin
            flash_reset_b_r <= 1'b1;
            st_r <= S_IDLE;
            done_r <= 1'b1;
          end
        end
        S_READ: begin
          ph_r <= ph_r + 3'd1;
          if (ph_r == 3'd0) begin
            flash_addr_r <= a_r;
            flash_chip_select_b_r <= 1'b0;
            flash_oe_b_r <= 1'b0;
          end else if (ph_r == `NFC_CYC_PHASE) begin
            rdata_r <= flash_dq_in;
            flash_chip_select_b_r <= 1'b1;
            flash_oe_b_r <= 1'b1;
            ph_r <= 3'd0;
            st_r <= S_IDLE;
            done_r <= 1'b1;
          end
        end
        default: begin
          fast_r <= 1'b0;
          secure_r <= 1'b0;
          flash_reset_b_r <= 1'b0;
          cnt_r <= 32'd0;
          st_r <= S_WAIT;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== sim/nfc_host_sva.sv
// Assertions on the flash pins of the host controller
`timescale 1ns/1ps
`default_nettype none
module nfc_host_sva #(
  parameter AW = 22
) (
  input wire logic          mclk,
  input wire logic          rst_b,
  input wire logic          elevated_id_voltage,
  input wire logic          done_r,
  input wire logic          err_r,
  input wire logic [AW-1:0] flash_addr_r,
  input wire logic [15:0]   flash_dq_out_r,
  input wire logic          flash_dq_oe_b_r,
  input wire logic          flash_chip_select_b_r,
  input wire logic          flash_we_b_r,
  input wire logic          flash_oe_b_r,
  input wire logic          flash_reset_b_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_write_qual: assert property ($fell(flash_we_b_r) |-> !flash_chip_select_b_r && flash_oe_b_r)
    else $error("write strobe without select");
  a_addr_steady: assert property (!flash_we_b_r |-> $stable(flash_addr_r))
    else $error("address moved during write pulse");
  a_data_steady: assert property (!flash_we_b_r |=> $stable(flash_dq_out_r) && !flash_dq_oe_b_r)
    else $error("data moved before write pulse ended");
  a_pulse_min: assert property ($fell(flash_we_b_r) |-> !flash_we_b_r [*2])
    else $error("write pulse too short");
  a_bus_free: assert property (!flash_oe_b_r |-> flash_dq_oe_b_r && flash_we_b_r)
    else $error("host drives data during read");
  a_unlock_first: assert property ($fell(flash_we_b_r) && flash_dq_out_r == 16'h00aa
    |-> flash_addr_r[10:0] == 11'h555)
    else $error("first unlock at wrong address");
  a_unlock_second: assert property ($fell(flash_we_b_r) && flash_dq_out_r == 16'h0055
    |-> flash_addr_r[10:0] == 11'h2aa)
    else $error("second unlock at wrong address");
  a_prot_volt: assert property ($fell(flash_we_b_r) && flash_dq_out_r == 16'h0040
    |-> elevated_id_voltage)
    else $error("protection without elevated voltage");
  a_prot_low: assert property ($fell(flash_we_b_r) && flash_dq_out_r == 16'h0040
    |-> {flash_addr_r[6], flash_addr_r[3:0]} == 5'b00010)
    else $error("protection low address bits wrong");
  a_reset_len: assert property ($fell(flash_reset_b_r) |-> !flash_reset_b_r [*4])
    else $error("flash reset pulse too short");
  a_reset_quiet: assert property (!flash_reset_b_r |-> flash_chip_select_b_r)
    else $error("flash selected during reset");
  cover property ($fell(flash_we_b_r) && flash_dq_out_r == 16'h0040);
  cover property (done_r);
  cover property (err_r);
  cover property ($fell(flash_reset_b_r));
endmodule
bind nfc_host nfc_host_sva #(.AW(AW)) u_sva (
  .mclk(mclk), .rst_b(rst_b), .elevated_id_voltage(elevated_id_voltage),
  .done_r(done_r), .err_r(err_r), .flash_addr_r(flash_addr_r),
  .flash_dq_out_r(flash_dq_out_r), .flash_dq_oe_b_r(flash_dq_oe_b_r),
  .flash_chip_select_b_r(flash_chip_select_b_r), .flash_we_b_r(flash_we_b_r),
  .flash_oe_b_r(flash_oe_b_r), .flash_reset_b_r(flash_reset_b_r)
);
`default_nettype wire

// ===== sim/nfc_flash_model.sv
// Behavioural flash die answering the host controller's bus
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
  parameter [15:0] DEV_CODE = 16'h1234, // Arbitrary identification value
  parameter        T_PROG   = 20,
  parameter        T_ERASE  = 60
) (
  input  wire logic        mclk,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        cs_b,
  input  wire logic        we_b,
  input  wire logic        oe_b,
  input  wire logic        reset_b,
  output logic      [15:0] dq_in,
  output logic             ready_busy_out
);
  logic [21:0] wa = 22'h0;
  logic [21:0] pa = 22'h3fffff;
  logic [15:0] pd = 16'hffff;
  logic [15:0] last = 16'h0;
  logic [15:0] val;
  logic [9:0]  grp = 10'h0;
  logic [1:0]  stp = 2'h0;
  logic        we_d = 1'b1;
  logic        arm_p = 1'b0, arm_e = 1'b0, fast = 1'b0, asel = 1'b0, secm = 1'b0, prot = 1'b0;
  integer      busy = 0;
  assign ready_busy_out = (busy == 0);
  always_comb begin
    val = (addr == pa) ? pd : 16'hffff;
    if (busy != 0 && addr == pa) val[7] = ~pd[7];
    if (asel && addr[7:0] == 8'h01) val = DEV_CODE;
    if (prot && addr[7:0] == 8'h02) val = {15'h0, addr[21:12] == grp};
    dq_in = (!cs_b && !oe_b) ? val : ~last;
  end
  always @(posedge mclk) begin
    we_d <= we_b;
    if (busy != 0) busy <= busy - 1;
    if (!cs_b && !oe_b) last <= val;
    if (!reset_b) begin
      {stp, arm_p, arm_e, fast, asel, secm, prot} <= 8'h0;
      busy <= 0;
    end else if (!we_b && we_d && !cs_b && oe_b) wa <= addr;
    else if (we_b && !we_d && !cs_b) begin
      stp <= 2'h0;
      if (arm_p) begin
        pa <= wa;
        pd <= dq_out;
        busy <= T_PROG;
        arm_p <= 1'b0;
      end else if (dq_out[7:0] == 8'hf0) {asel, prot} <= 2'b00;
      else if (stp == 0 && dq_out[7:0] == 8'haa && wa[10:0] == 11'h555) stp <= 2'h1;
      else if (stp == 1 && dq_out[7:0] == 8'h55 && wa[10:0] == 11'h2aa) stp <= 2'h2;
      else if (stp == 2) begin
        case (dq_out[7:0])
          8'ha0: arm_p <= 1'b1;
          8'h80: arm_e <= 1'b1;
          8'h10, 8'h30: if (arm_e) begin
            busy <= T_ERASE;
            pd <= 16'hffff;
            arm_e <= 1'b0;
          end
          8'h90: asel <= 1'b1;
          8'h20: fast <= 1'b1;
          8'h88: secm <= 1'b1;
          default: ;
        endcase
      end else if (fast && dq_out[7:0] == 8'ha0) arm_p <= 1'b1;
      else if (fast && dq_out[7:0] == 8'h90) fast <= 1'b0;
      else if (secm && asel && dq_out[7:0] == 8'h00) {secm, asel} <= 2'b00;
      else if (dq_out[7:0] == 8'h40) begin
        grp <= wa[21:12];
        prot <= 1'b1;
      end else arm_e <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/test_nor_flash_command_decoder.sv
// Self-checking bench for the flash command host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module test_nor_flash_command_decoder;
  localparam [15:0] DEV = 16'h1234; // Arbitrary identification value
  localparam [17:0] OK  = 18'h0;
  localparam [17:0] BAD = 18'h10000;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        elevated_id_voltage = 1'b0;
  logic [3:0]  cmd_op = 4'h0;
  logic [21:0] cmd_addr = 22'h0;
  logic [15:0] cmd_data = 16'h0;
  wire         cmd_ready, done_r, err_r, dq_oe_b, cs_b, we_b, oe_b, reset_b, ready_busy_out;
  wire  [15:0] rdata_r, dq_out, dq_in;
  wire  [21:0] flash_addr;
  logic [17:0] exp_q[$];
  logic [17:0] ex;
  logic [21:0] pa, ga;
  logic [15:0] pd;
  integer      n_mismatch = 0;
  integer      comparisons = 0;
  nfc_host #(.CYC_READY(50), .CYC_SPD(50), .CYC_PROG(500), .CYC_ERASE(2000)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .done_r(done_r),
    .err_r(err_r), .rdata_r(rdata_r), .elevated_id_voltage(elevated_id_voltage),
    .flash_addr_r(flash_addr), .flash_dq_in(dq_in), .flash_dq_out_r(dq_out),
    .flash_dq_oe_b_r(dq_oe_b), .flash_chip_select_b_r(cs_b), .flash_we_b_r(we_b),
    .flash_oe_b_r(oe_b), .flash_reset_b_r(reset_b), .ready_busy_out(ready_busy_out));
  nfc_flash_model #(.DEV_CODE(DEV)) flash_u (
    .mclk(mclk), .addr(flash_addr), .dq_out(dq_out), .cs_b(cs_b), .we_b(we_b),
    .oe_b(oe_b), .reset_b(reset_b), .dq_in(dq_in), .ready_busy_out(ready_busy_out));
  task automatic stop_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Issue one operation and wait until its result has been checked
  task automatic run(input logic [3:0] o, input logic [21:0] a, input logic [15:0] d,
                     input logic [17:0] e);
    integer i;
    begin
      @(posedge mclk);
      #1;
      exp_q.push_back(e);
      cmd_op = o;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      i = 0;
      do begin @(posedge mclk); i++; end while (cmd_ready !== 1'b1 && i < 100);
      #1 cmd_valid = 1'b0;
      i = 0;
      while (exp_q.size() > 0 && i < 5000) begin @(posedge mclk); i++; end
      if (i >= 5000 || exp_q.size() > 0) begin
        n_mismatch++;
        stop_test();
      end
    end
  endtask
  always @(negedge mclk) if (done_r === 1'b1 || err_r === 1'b1) begin
    if (exp_q.size() == 0) `CHK("result", 1'b1, 1'b0)
    else begin
      ex = exp_q.pop_front();
      `CHK("err", err_r, ex[16])
      if (ex[17]) `CHK("rdata", rdata_r, ex[15:0])
    end
  end
  initial forever #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9ce150f1));
    pa = 22'($urandom);
    pa[7:0] = 8'h40;
    pd = 16'($urandom) | 16'h0100;
    ga = {10'($urandom), 12'h002};
    repeat (10) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    run(4'h1, pa, pd, OK);
    run(4'hd, pa, 16'h0, {2'b10, pd});
    run(4'h2, 22'h0, 16'h0, OK);
    run(4'h3, pa, 16'h0, OK);
    run(4'h4, pa, 16'h0, OK);
    run(4'h5, pa, 16'h0, OK);
    run(4'h8, 22'h0, 16'h0, BAD);
    run(4'h7, 22'h0, 16'h0, OK);
    run(4'h1, pa ^ 22'h100, pd ^ 16'h00ff, OK);
    run(4'h8, 22'h0, 16'h0, OK);
    run(4'hd, pa ^ 22'h100, 16'h0, {2'b10, pd ^ 16'h00ff});
    run(4'h6, pa, 16'h0, OK);
    run(4'hd, {pa[21:19], 19'h1}, 16'h0, {2'b10, DEV});
    run(4'h0, pa, 16'h0, OK);
    run(4'h9, ga, 16'h0, BAD);
    #1 elevated_id_voltage = 1'b1;
    run(4'h9, ga, 16'h0, {2'b10, 16'h0001});
    run(4'h0, 22'h0, 16'h0, OK);
    run(4'hb, 22'h0, 16'h0, OK);
    run(4'h1, 22'h00007f, pd, OK);
    run(4'hc, pa, 16'h0, OK);
    run(4'hc, 22'h0, 16'h0, BAD);
    run(4'ha, 22'h0, 16'h0, OK);
    run(4'he, 22'h0, 16'h0, OK);
    run(4'hf, 22'h0, 16'h0, BAD);
    stop_test();
  end
endmodule
`default_nettype wire
